//--- eif_bus_master.sv
// Purpose: behavioural two-wire bus master facing the slave front end
// Assumes: open-drain data line with pull-up resolved in the bench; clock driven push-pull
// Notes:   clock stands high between frames; slow clock to clear spike filter
module eif_bus_master (
    // bus lines
    output logic scl,
    output logic sda_drv,
    input  wire  sda
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int Q = 160; // quarter period, well above the spike time

    // idle bus: both lines released
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // start from idle or as a repeated start
    task automatic start;
        sda_drv <= 1'b1;
        #Q scl <= 1'b1;
        #Q sda_drv <= 1'b0;
        #Q scl <= 1'b0;
        #Q;
    endtask
    // stop then bus free time
    task automatic stop;
        sda_drv <= 1'b0;
        #Q scl <= 1'b1;
        #Q sda_drv <= 1'b1;
        #(4 * Q);
    endtask
    // data set while clock low, sampled mid high phase
    task automatic bit_x(input logic b, output logic r);
        sda_drv <= b;
        #Q scl <= 1'b1;
        #Q r = sda;
        #Q scl <= 1'b0;
        #Q;
    endtask
    // eight data bits then the ninth clock; mack drives a read ack
    task automatic xfer(input logic [7:0] d, input logic mack,
                        output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
            q[i] = r;
        end
        bit_x(!mack, r);
        ack = !r;
    endtask
endmodule

//--- eif_glitch_filter.v
// Purpose: two-flop synchroniser plus spike filter for one pin
// Assumes: pin is asynchronous to ref_clk
// Notes:   output changes only after the input holds steady past the spike time
`include "eif_map.vh"
module eif_glitch_filter #(
    parameter RESET_VAL = 1'b1
) (
    // clock and reset
    input  wire ref_clk,
    input  wire rstn,
    // pin and filtered level
    input  wire pin_in,
    output reg  level_out
);
    localparam integer           LIMIT_I = `EIF_SPIKE_CYC;
    localparam [`EIF_FILT_W-1:0] LIMIT   = LIMIT_I[`EIF_FILT_W-1:0];

    reg                   sync1_r;
    reg                   sync2_r;
    reg [`EIF_FILT_W-1:0] cnt_r;

    // first flop feeds only the second
    always @(posedge ref_clk) begin
        if (!rstn) begin
            sync1_r   <= RESET_VAL;
            sync2_r   <= RESET_VAL;
            cnt_r     <= 4'h0;
            level_out <= RESET_VAL;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            // a difference must persist beyond the spike time to be taken
            if (sync2_r == level_out) begin
                cnt_r <= 4'h0;
            end else if (cnt_r >= LIMIT) begin
                level_out <= sync2_r;
                cnt_r     <= 4'h0;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule

//--- eif_i2c_slave.v
// Purpose: two-wire slave front end of a battery-backed serial SRAM
// Assumes: serial clock and data arrive asynchronously and are oversampled
// Notes:   array and register contents live outside; this block decodes and acks
//
// Summary of operation
// - data falling while clock high is a Start.
// - data rising while clock high is a Stop.
// - any data change while clock high is Start or Stop, never data.
// - transmitter changes data only while clock low; one bit per pulse.
// - receiver holds data low through ninth clock high phase.
// - on master's refused acknowledge, device releases data line.
// - first byte after Start is control byte: opcode, two selects, zero, direction.
// - respond only if selects match pins and fixed bit is zero.
// - last control bit one means read, zero means write.
// - opcode 1010 selects array, 0011 selects control registers.
// - valid slave address is acknowledged.
// - capacitor below trip threshold: acknowledge nothing.
// - array write acks address bytes; data refused in protected block.
// - 33h or DDh to register 55h starts store or recall, acked.
// - other value to command register: data byte refused.
// - register write to unknown address: address and later bytes refused.
// - two bytes after control byte load pointer, high part first.
// - after protected refusal, ignore line until new Start, pointer held.
// - hardware or automatic store aborts any ongoing access.
`include "eif_map.vh"
module eif_i2c_slave (
    // clock and reset
    input  wire                   ref_clk,
    input  wire                   rstn,
    // two-wire bus pins
    input  wire                   scl_in,
    input  wire                   sda_in,
    output reg                    sda_out,
    output reg                    sda_oe,
    // strap and supply status pins
    input  wire                   chip_select_upper_pin,
    input  wire                   chip_select_lower_pin,
    input  wire                   hardware_store_pin,
    input  wire                   cap_below_trip,
    input  wire                   auto_store_req,
    // array interface
    input  wire                   block_protected,
    input  wire [7:0]             rd_data,
    output reg  [`EIF_ADDR_W-1:0] addr_ptr,
    output reg  [7:0]             wr_data,
    output reg                    sram_wr_stb,
    output reg                    sram_rd_stb,
    output reg                    status_wr_stb,
    output reg                    creg_rd_stb,
    // store and recall requests
    output reg                    sw_store_stb,
    output reg                    sw_recall_stb,
    output reg                    hw_store_stb,
    output reg                    busy
);
    // states, one-hot
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_RX   = 6'h02;
    localparam [5:0] ST_RACK = 6'h04;
    localparam [5:0] ST_TX   = 6'h08;
    localparam [5:0] ST_TACK = 6'h10;
    localparam [5:0] ST_IGN  = 6'h20;

    // byte roles in a write
    localparam [2:0] BY_CTRL  = 3'h0;
    localparam [2:0] BY_AHI   = 3'h1;
    localparam [2:0] BY_ALO   = 3'h2;
    localparam [2:0] BY_DATA  = 3'h3;
    localparam [2:0] BY_RADDR = 3'h4;
    localparam [2:0] BY_RDAT  = 3'h5;

    wire scl_f;
    wire sda_f;
    wire hs_f;

    reg                   scl_d_r;
    reg                   sda_d_r;
    reg                   hs_d_r;
    reg                   aux_s1_r;
    reg                   aux_s2_r;
    reg                   cap_s1_r;
    reg                   cap_s2_r;
    reg [5:0]             st_r;
    reg [5:0]             st_nxt;
    reg [2:0]             bit_r;
    reg [7:0]             sh_r;
    reg [2:0]             role_r;
    reg                   is_sram_r;
    reg                   ack_r;
    reg [7:0]             reg_addr_r;
    reg [`EIF_ADDR_W-1:0] ptr_r;
    reg                   nine_r;

    // clock, data and store pins are filtered (the filter includes the two-flop sync)
    eif_glitch_filter #(.RESET_VAL(1'b1)) u_scl (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .pin_in    (scl_in),
        .level_out (scl_f)
    );
    eif_glitch_filter #(.RESET_VAL(1'b1)) u_sda (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .pin_in    (sda_in),
        .level_out (sda_f)
    );
    eif_glitch_filter #(.RESET_VAL(1'b0)) u_hs (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .pin_in    (hardware_store_pin),
        .level_out (hs_f)
    );

    wire scl_rise  = scl_f & ~scl_d_r;
    wire scl_fall  = ~scl_f & scl_d_r;
    // data edges while clock stays high are bus conditions
    wire start_det = scl_f & scl_d_r & sda_d_r & ~sda_f;
    wire stop_det  = scl_f & scl_d_r & ~sda_d_r & sda_f;
    wire hs_rise   = hs_f & ~hs_d_r;
    wire abort     = hs_rise | aux_s2_r;
    wire [7:0] rx_byte = {sh_r[6:0], sda_f};

    // control byte check against straps and opcode
    function ctrl_ok;
        input [7:0] cb;
        input       up;
        input       lo;
        begin
            ctrl_ok = ((cb[`EIF_CB_OP_HI:`EIF_CB_OP_LO] == `EIF_OP_SRAM) ||
                       (cb[`EIF_CB_OP_HI:`EIF_CB_OP_LO] == `EIF_OP_CREG)) &&
                      (cb[`EIF_CB_CS_UP] == up) && (cb[`EIF_CB_CS_LO] == lo) &&
                      (cb[`EIF_CB_CS_FIX] == 1'b0);
        end
    endfunction

    // edge history and syncs for level inputs from other logic domains
    always @(posedge ref_clk) begin
        if (!rstn) begin
            scl_d_r  <= 1'b1;
            sda_d_r  <= 1'b1;
            hs_d_r   <= 1'b0;
            aux_s1_r <= 1'b0;
            aux_s2_r <= 1'b0;
            cap_s1_r <= 1'b1;
            cap_s2_r <= 1'b1;
        end else begin
            scl_d_r  <= scl_f;
            sda_d_r  <= sda_f;
            hs_d_r   <= hs_f;
            aux_s1_r <= auto_store_req;
            aux_s2_r <= aux_s1_r;
            cap_s1_r <= cap_below_trip;
            cap_s2_r <= cap_s1_r;
        end
    end

    // next state
    always @* begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: st_nxt = ST_IDLE;
            ST_RX: begin
                if (scl_rise && bit_r == 3'h7) begin
                    st_nxt = ST_RACK;
                end
            end
            ST_RACK: begin
                // decision made on the ninth falling edge
                if (scl_fall && nine_r) begin
                    if (!ack_r) begin
                        st_nxt = ST_IGN;
                    end else if (role_r == BY_CTRL && sh_r[`EIF_CB_RW]) begin
                        st_nxt = ST_TX;
                    end else begin
                        st_nxt = ST_RX;
                    end
                end
            end
            ST_TX: begin
                if (scl_fall && bit_r == 3'h7) begin
                    st_nxt = ST_TACK;
                end
            end
            ST_TACK: begin
                if (scl_rise) begin
                    st_nxt = sda_f ? ST_IGN : ST_TACK;
                end else if (scl_fall) begin
                    st_nxt = ST_TX;
                end
            end
            ST_IGN:  st_nxt = ST_IGN;
            default: st_nxt = ST_IDLE;
        endcase
        if (start_det) begin
            st_nxt = ST_RX;
        end else if (stop_det || abort || cap_s2_r) begin
            st_nxt = ST_IDLE;
        end
    end

    // datapath and bus driving
    always @(posedge ref_clk) begin
        if (!rstn) begin
            st_r          <= ST_IDLE;
            bit_r         <= 3'h0;
            sh_r          <= 8'h00;
            role_r        <= BY_CTRL;
            is_sram_r     <= 1'b0;
            ack_r         <= 1'b0;
            nine_r        <= 1'b0;
            reg_addr_r    <= 8'h00;
            ptr_r         <= 11'h000;
            addr_ptr      <= 11'h000;
            wr_data       <= 8'h00;
            sram_wr_stb   <= 1'b0;
            sram_rd_stb   <= 1'b0;
            status_wr_stb <= 1'b0;
            creg_rd_stb   <= 1'b0;
            sw_store_stb  <= 1'b0;
            sw_recall_stb <= 1'b0;
            hw_store_stb  <= 1'b0;
            busy          <= 1'b0;
            sda_out       <= 1'b0;
            sda_oe        <= 1'b0;
        end else begin
            st_r          <= st_nxt;
            addr_ptr      <= ptr_r;
            sram_wr_stb   <= 1'b0;
            sram_rd_stb   <= 1'b0;
            status_wr_stb <= 1'b0;
            creg_rd_stb   <= 1'b0;
            sw_store_stb  <= 1'b0;
            sw_recall_stb <= 1'b0;
            hw_store_stb  <= hs_rise;
            busy          <= (st_nxt != ST_IDLE) && (st_nxt != ST_IGN);
            sda_out       <= 1'b0;
            if (start_det) begin
                bit_r  <= 3'h0;
                role_r <= BY_CTRL;
                sda_oe <= 1'b0;
            end else if (st_nxt == ST_IDLE || st_nxt == ST_IGN) begin
                sda_oe <= 1'b0; // release line on stop, abort or refusal
            end else begin
                case (st_r)
                    ST_RX: begin
                        // sample on rising clock only; data is stable then
                        if (scl_rise) begin
                            sh_r  <= rx_byte;
                            bit_r <= bit_r + 3'h1;
                            if (bit_r == 3'h7) begin
                                nine_r <= 1'b0; // ack slot opens
                                case (role_r)
                                    BY_CTRL: begin
                                        ack_r     <= ctrl_ok(rx_byte,
                                                     chip_select_upper_pin,
                                                     chip_select_lower_pin);
                                        is_sram_r <= (rx_byte[7:4] == `EIF_OP_SRAM);
                                    end
                                    BY_AHI:   ack_r <= 1'b1;
                                    BY_ALO:   ack_r <= 1'b1;
                                    BY_DATA:  ack_r <= ~block_protected;
                                    BY_RADDR: ack_r <= (rx_byte == `EIF_REG_STATUS) ||
                                                       (rx_byte == `EIF_REG_COMMAND);
                                    BY_RDAT: begin
                                        if (reg_addr_r == `EIF_REG_COMMAND) begin
                                            ack_r <= (rx_byte == `EIF_CMD_STORE) ||
                                                     (rx_byte == `EIF_CMD_RECALL);
                                        end else begin
                                            ack_r <= 1'b1;
                                        end
                                    end
                                    default:  ack_r <= 1'b0;
                                endcase
                            end
                        end
                        // release the line on a clock fall at bit zero when ack_r is set
                        if (scl_fall && bit_r == 3'h0 && ack_r) begin
                            sda_oe <= 1'b0;
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            // ack clock rising: commit the byte
                            nine_r <= 1'b1;
                            case (role_r)
                                BY_AHI: ptr_r <= {sh_r[`EIF_ADDR_W-9:0], 8'h00};
                                BY_ALO: ptr_r <= {ptr_r[`EIF_ADDR_W-1:8], sh_r};
                                BY_DATA: begin
                                    if (ack_r) begin
                                        wr_data     <= sh_r;
                                        sram_wr_stb <= 1'b1;
                                        ptr_r       <= ptr_r + 11'h001;
                                    end
                                end
                                BY_RADDR: reg_addr_r <= sh_r;
                                BY_RDAT: begin
                                    wr_data <= sh_r;
                                    if (reg_addr_r == `EIF_REG_STATUS) begin
                                        status_wr_stb <= 1'b1;
                                    end else begin
                                        sw_store_stb  <= (sh_r == `EIF_CMD_STORE);
                                        sw_recall_stb <= (sh_r == `EIF_CMD_RECALL);
                                    end
                                end
                                default: ;
                            endcase
                        end
                        if (scl_fall && nine_r) begin
                            bit_r  <= 3'h0;
                            sda_oe <= 1'b0;
                            if (role_r == BY_CTRL && sh_r[`EIF_CB_RW]) begin
                                // first read bit driven at once in the low phase
                                sda_oe <= ~rd_data[7];
                                if (is_sram_r) begin
                                    sram_rd_stb <= 1'b1;
                                end else begin
                                    creg_rd_stb <= 1'b1;
                                end
                            end
                            case (role_r)
                                BY_CTRL: role_r <= is_sram_r ? BY_AHI : BY_RADDR;
                                BY_AHI:  role_r <= BY_ALO;
                                BY_ALO:  role_r <= BY_DATA;
                                BY_RADDR: role_r <= BY_RDAT;
                                default: role_r <= role_r;
                            endcase
                        end else if (scl_f == 1'b0 && ack_r && !scl_fall) begin
                            sda_oe <= 1'b1;
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            bit_r <= bit_r + 3'h1;
                            if (bit_r == 3'h7) begin
                                sda_oe <= 1'b0; // master's ack slot
                                if (is_sram_r) begin
                                    ptr_r <= ptr_r + 11'h001;
                                end
                            end else begin
                                sda_oe <= ~rd_data[3'h6 - bit_r];
                            end
                        end
                    end
                    ST_TACK: begin
                        if (scl_fall) begin
                            bit_r  <= 3'h0;
                            sda_oe <= ~rd_data[7];
                            if (is_sram_r) begin
                                sram_rd_stb <= 1'b1;
                            end else begin
                                creg_rd_stb <= 1'b1;
                            end
                        end
                    end
                    default: sda_oe <= 1'b0;
                endcase
            end
        end
    end
endmodule

//--- eif_i2c_slave_bench.sv
// Purpose: self-checking bench for the two-wire slave front end
// Assumes: upper select strapped high, lower low; read data from pointer
// Notes:   strobes are counted so pulses between checks are not lost
`include "eif_map.vh"
module eif_i2c_slave_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic cs_up = 1'b1;
    logic cs_lo = 1'b0;
    logic hs = 1'b0;
    logic cap = 1'b0;
    logic prot = 1'b0;
    logic auto_st = 1'b0;
    wire scl;
    wire sda_drv;
    wire sda_out, sda_oe, sram_wr_stb, sram_rd_stb, status_wr_stb, creg_rd_stb;
    wire sw_store_stb, sw_recall_stb, hw_store_stb, busy;
    wire [`EIF_ADDR_W-1:0] addr_ptr;
    wire [7:0] wr_data;
    wire [7:0] rd_data = addr_ptr[7:0] ^ 8'h5a; // known pattern per address
    wire sda_in = sda_drv & ~sda_oe; // pull-up wins unless someone pulls low
    int n_fail = 0;
    int samples_checked = 0;
    int n_wr = 0;
    int n_st = 0;
    int n_rc = 0;
    int n_hs = 0;
    int n_sw = 0;

    eif_i2c_slave dut (
        .ref_clk(ref_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_upper_pin(cs_up),
        .chip_select_lower_pin(cs_lo), .hardware_store_pin(hs),
        .cap_below_trip(cap), .auto_store_req(auto_st), .block_protected(prot),
        .rd_data(rd_data), .addr_ptr(addr_ptr), .wr_data(wr_data),
        .sram_wr_stb(sram_wr_stb), .sram_rd_stb(sram_rd_stb),
        .status_wr_stb(status_wr_stb), .creg_rd_stb(creg_rd_stb),
        .sw_store_stb(sw_store_stb), .sw_recall_stb(sw_recall_stb),
        .hw_store_stb(hw_store_stb), .busy(busy)
    );
    eif_bus_master m (.scl(scl), .sda_drv(sda_drv), .sda(sda_in));

    // clock and strobe counters
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        n_wr <= n_wr + int'(sram_wr_stb === 1'b1);
        n_st <= n_st + int'(sw_store_stb === 1'b1);
        n_rc <= n_rc + int'(sw_recall_stb === 1'b1);
        n_hs <= n_hs + int'(hw_store_stb === 1'b1);
        n_sw <= n_sw + int'(status_wr_stb === 1'b1);
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] cb(input logic [3:0] op, input logic rw);
        return {op, cs_up, cs_lo, 1'b0, rw};
    endfunction
    // write a byte and judge the slave's answer
    task automatic wb(input logic [7:0] d, input logic exp_ack);
        logic [7:0] q;
        logic a;
        m.xfer(d, 1'b0, q, a);
        chk(a, exp_ack);
    endtask
    // read a byte, master answers with mack
    task automatic rb(input logic mack, input logic [7:0] exp);
        logic [7:0] q;
        logic a;
        m.xfer(8'hff, mack, q, a);
        chk(q, exp);
    endtask
    // register write of address then data
    task automatic creg_wr(input logic [7:0] ad, input logic [7:0] d,
                           input logic ack_a, input logic ack_d);
        m.start;
        wb(cb(`EIF_OP_CREG, 1'b0), 1'b1);
        wb(ad, ack_a);
        wb(d, ack_d);
        m.stop;
    endtask

    // pointer load high part first, two writes across the array end
    task automatic t_sram_write;
        int w0;
        w0 = n_wr;
        m.start;
        wb(cb(`EIF_OP_SRAM, 1'b0), 1'b1);
        wb(8'h07, 1'b1);
        wb(8'hff, 1'b1);
        wb(8'hc3, 1'b1);
        wb(8'h3c, 1'b1);
        m.stop;
        chk(16'(n_wr - w0), 16'd2);
        chk(wr_data, 8'h3c);
        chk(addr_ptr, 11'h001);
    endtask
    // sequential read from the pointer, master ends with refusal
    task automatic t_read;
        m.start;
        wb(cb(`EIF_OP_SRAM, 1'b1), 1'b1);
        rb(1'b1, 8'h5b);
        rb(1'b0, 8'h58);
        chk(sda_oe, 1'b0);
        m.stop;
    endtask
    // protected data refused, later bytes ignored, pointer held
    task automatic t_protected;
        int w0;
        w0 = n_wr;
        @(posedge ref_clk);
        prot <= 1'b1;
        m.start;
        wb(cb(`EIF_OP_SRAM, 1'b0), 1'b1);
        wb(8'h00, 1'b1);
        wb(8'h10, 1'b1);
        wb(8'h99, 1'b0);
        wb(8'h98, 1'b0);
        m.stop;
        prot <= 1'b0;
        chk(16'(n_wr - w0), 16'd0);
        chk(addr_ptr, 11'h010);
    endtask
    // store, recall, bad command, status write, bad register
    task automatic t_creg;
        int s0;
        int r0;
        int w0;
        s0 = n_st;
        r0 = n_rc;
        w0 = n_sw;
        creg_wr(8'h55, 8'h33, 1'b1, 1'b1);
        creg_wr(8'h55, 8'hdd, 1'b1, 1'b1);
        creg_wr(8'h55, 8'h12, 1'b1, 1'b0);
        creg_wr(8'h00, 8'h02, 1'b1, 1'b1);
        creg_wr(8'h20, 8'h33, 1'b0, 1'b0);
        chk(16'(n_st - s0), 16'd1);
        chk(16'(n_rc - r0), 16'd1);
        chk(16'(n_sw - w0), 16'd1);
    endtask
    // wrong selects, fixed bit set, unknown code, then capacitor low
    task automatic t_refuse;
        logic [7:0] bad [3] = '{8'ha4, 8'haa, 8'h58};
        foreach (bad[i]) begin
            m.start;
            wb(bad[i], 1'b0);
            m.stop;
        end
        @(posedge ref_clk);
        cap <= 1'b1;
        m.start;
        wb(cb(`EIF_OP_SRAM, 1'b0), 1'b0);
        m.stop;
        cap <= 1'b0;
    endtask
    // store pin in mid byte, or auto store request from the start of a byte, aborts the access
    task automatic t_hs_abort;
        logic [7:0] q;
        logic a;
        int h0;
        h0 = n_hs;
        m.start;
        wb(cb(`EIF_OP_SRAM, 1'b0), 1'b1);
        fork
            m.xfer(8'h01, 1'b0, q, a);
            begin
                repeat (600) @(posedge ref_clk);
                hs <= 1'b1;
                repeat (100) @(posedge ref_clk);
                hs <= 1'b0;
            end
        join
        chk(a, 1'b0);
        m.stop;
        chk(16'(n_hs - h0), 16'd1);
        chk(busy, 1'b0);
        m.start;
        wb(cb(`EIF_OP_SRAM, 1'b0), 1'b1);
        auto_st <= 1'b1;
        wb(8'h02, 1'b0);
        auto_st <= 1'b0;
        m.stop;
    endtask

    task automatic results;
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // watchdog sized well above the expected run of about 230 us
    initial begin
        #360000;
        n_fail++;
        results;
    end
    // reset, filter settling, then the scenarios
    initial begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (40) @(posedge ref_clk);
        t_sram_write;
        t_read;
        t_protected;
        t_creg;
        t_refuse;
        t_hs_abort;
        results;
    end
endmodule

//--- eif_i2c_slave_props.sv
// Purpose: port-level checker for the two-wire slave front end
// Assumes: single ref_clk domain, rstn synchronous active low
// Notes:   pin-side delays of sync and spike filter absorbed by small windows
`include "eif_map.vh"
module eif_i2c_slave_props (
    // clock and reset
    input wire                   ref_clk,
    input wire                   rstn,
    // bus and status pins
    input wire                   scl_in,
    input wire                   sda_in,
    input wire                   sda_out,
    input wire                   sda_oe,
    input wire                   hardware_store_pin,
    input wire                   cap_below_trip,
    input wire                   auto_store_req,
    // strobes and state
    input wire [7:0]             wr_data,
    input wire                   sram_wr_stb,
    input wire                   sw_store_stb,
    input wire                   sw_recall_stb,
    input wire                   hw_store_stb,
    input wire                   busy
);
    default clocking cb_clk @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // stop on the pins, and a store pulse held for eight cycles
    sequence s_stop;
        scl_in && $rose(sda_in);
    endsequence
    sequence s_hs_held;
        $rose(hardware_store_pin) ##1 hardware_store_pin [*7];
    endsequence

    a_sda_out_low: assert property (sda_oe |-> !sda_out)
        else $error("data driven high");
    a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("data drive started while clock high");
    a_ack_stable: assert property (sda_oe && scl_in && !hardware_store_pin
        && !auto_store_req && !cap_below_trip |=> sda_oe)
        else $error("data released during clock high");
    a_cap_no_ack: assert property (cap_below_trip [*8] |-> !sda_oe)
        else $error("drive while capacitor low");
    a_wr_in_ack: assert property (sram_wr_stb |-> scl_in && busy)
        else $error("array write outside ack clock high");
    a_store_code: assert property (sw_store_stb |-> ##[0:1] wr_data == 8'h33)
        else $error("store without store code");
    a_recall_code: assert property (sw_recall_stb |-> ##[0:1] wr_data == 8'hdd)
        else $error("recall without recall code");
    a_hs_store: assert property (s_hs_held |-> ##[1:20] hw_store_stb)
        else $error("store pin not seen");
    a_stop_idle: assert property (s_stop |-> ##[1:40] !busy)
        else $error("busy after stop");
endmodule

bind eif_i2c_slave eif_i2c_slave_props u_props (
    .ref_clk(ref_clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .hardware_store_pin(hardware_store_pin),
    .cap_below_trip(cap_below_trip), .auto_store_req(auto_store_req),
    .wr_data(wr_data), .sram_wr_stb(sram_wr_stb), .sw_store_stb(sw_store_stb),
    .sw_recall_stb(sw_recall_stb), .hw_store_stb(hw_store_stb), .busy(busy)
);

//--- eif_map.vh
// Purpose: constants for the two-wire slave front end
// Assumes: ref_clk at 250 MHz (4 ns)
// Notes:   times in ns, counts derived from the clock period
`ifndef EIF_MAP_VH
`define EIF_MAP_VH

`define EIF_CLK_PERIOD_NS   4
`define EIF_SPIKE_NS        50
// spike filter: longest pulse to reject in cycles, rounded down, no lower bound (12 here)
`define EIF_SPIKE_CYC       ((`EIF_SPIKE_NS) / (`EIF_CLK_PERIOD_NS))
`define EIF_FILT_W          4

`define EIF_OP_SRAM         4'ha
`define EIF_OP_CREG         4'h3
`define EIF_CB_OP_HI        7
`define EIF_CB_OP_LO        4
`define EIF_CB_CS_UP        3
`define EIF_CB_CS_LO        2
`define EIF_CB_CS_FIX       1
`define EIF_CB_RW           0

`define EIF_REG_STATUS      8'h00
`define EIF_REG_COMMAND     8'h55
`define EIF_CMD_STORE       8'h33
`define EIF_CMD_RECALL      8'hdd

`define EIF_ADDR_W          11

`endif
